/* File: rtl/vinc_source.sv */
`timescale 1ns/1ps
// Operation
// [R1] Sink sends Request before sequence starts
// [R2] Source answers Request with Accept
// [R3] Sink starts transition timer on Accept
// [R4] Sink returns GoodCRC, then evaluates Accept
// [R5] Source waits transition time after GoodCRC
// [R6] Sink drops to standby within standby time
// [R7] Standby completes before source transition wait
// [R8] After wait, source orders new voltage
// [R9] Supply ready within ready time
// [R10] Supply readiness forwarded to source engine
// [R11] Source sends PS_RDY, expects GoodCRC
// [R12] Sink acks PS_RDY, permits new level
// [R13] Sink draws new power any time after
// [R14] Sink keeps load transients within limits; not done in the sink logic, left to the supply
// [R15] Every wait is a loadable cycle counter
module vinc_source (
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    vinc_link_if.src                          link,
    input  wire logic [vinc_pkg::TIMER_W-1:0] src_transition_cycles,
    input  wire logic [vinc_pkg::TIMER_W-1:0] src_ready_cycles,
    input  wire logic                         supply_ready,
    output logic                              supply_change,
    output logic                              busy,
    output logic                              contract_done,
    output logic                              ready_timeout
);
    import vinc_pkg::*;

    // ==========================================
    // State encoding and register image
    typedef enum logic [2:0] {
        S_IDLE,
        S_WAIT_ACC_CRC,
        S_TRANSITION,
        S_SUPPLY,
        S_WAIT_RDY_CRC
    } src_state_e;

    typedef struct packed {
        src_state_e state;
        logic       tx_valid;
        msg_e       tx_msg;
        logic       supply_change;
        logic       busy;
        logic       contract_done;
        logic       ready_timeout;
        logic       trans_start;
        logic       ready_start;
        logic       ack_start;
        logic       ready_armed;
    } src_s;

    src_s st;
    src_s next_st;
    logic trans_done;
    logic ready_done;
    logic rx_crc;
    logic rx_req;
    logic ack_done;

    // ==========================================
    // Link decode; unexpected codes fall away silently
    always_comb begin
        rx_crc = 1'b0;
        rx_req = 1'b0;
        if (link.valid_to_src) begin
            case (link.msg_to_src)
                MSG_REQUEST: begin
                    rx_req = 1'b1;
                end
                MSG_GOODCRC: begin
                    rx_crc = 1'b1;
                end
                default: begin
                    rx_req = 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // Wait counters
    // Transition wait starts on the GoodCRC that acks the Accept
    wait_timer u_trans (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (st.trans_start),
        .load    (src_transition_cycles),
        .done    (trans_done)
    ); // [R15]

    // Ready limit only flags; the supply is still waited for
    wait_timer u_ready (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (st.ready_start),
        .load    (src_ready_cycles),
        .done    (ready_done)
    ); // [R15]

    // No retry: a missing ack drops the contract instead of hanging
    wait_timer u_ack (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (st.ack_start),
        .load    (src_transition_cycles),
        .done    (ack_done)
    ); // [R15]

    // ==========================================
    // Sequencer
    always_comb begin
        // Strobes and pulses are cleared every cycle below
        next_st               = st;
        next_st.tx_valid      = 1'b0;
        next_st.tx_msg        = MSG_NONE;
        next_st.contract_done = 1'b0;
        next_st.trans_start   = 1'b0;
        next_st.ready_start   = 1'b0;
        next_st.ack_start     = 1'b0;
        case (st.state)
            S_IDLE: begin
                // Sequence only opens on a pending request
                if (rx_req) begin // [R1]
                    next_st.tx_valid      = 1'b1;
                    next_st.tx_msg        = MSG_ACCEPT; // [R2]
                    next_st.ack_start     = 1'b1;
                    next_st.busy          = 1'b1;
                    next_st.ready_timeout = 1'b0;
                    next_st.state         = S_WAIT_ACC_CRC;
                end
            end
            S_WAIT_ACC_CRC: begin
                // Wait is timed from the ack, not from the Accept
                if (rx_crc) begin
                    next_st.trans_start = 1'b1; // [R5]
                    next_st.state       = S_TRANSITION;
                end else if (ack_done) begin
                    next_st.busy  = 1'b0;
                    next_st.state = S_IDLE;
                end
            end
            S_TRANSITION: begin
                // Ready level left over from before must drop first
                next_st.ready_armed = !supply_ready;
                // Sink standby must land inside this window
                if (trans_done) begin // [R7]
                    next_st.supply_change = 1'b1; // [R8]
                    next_st.ready_start   = 1'b1; // [R9]
                    next_st.state         = S_SUPPLY;
                end
            end
            S_SUPPLY: begin
                if (!supply_ready) begin
                    next_st.ready_armed = 1'b1;
                end
                if (supply_ready && st.ready_armed) begin // [R10]
                    // supply_change stands until ready is seen
                    next_st.supply_change = 1'b0;
                    next_st.tx_valid      = 1'b1;
                    next_st.tx_msg        = MSG_PS_RDY; // [R11]
                    next_st.ack_start     = 1'b1;
                    next_st.state         = S_WAIT_RDY_CRC;
                end else if (ready_done) begin
                    // Late supply flagged, still waits for it
                    next_st.ready_timeout = 1'b1; // [R9]
                end
            end
            S_WAIT_RDY_CRC: begin
                // Contract holds only once the sink has acked PS_RDY
                if (rx_crc) begin // [R11]
                    next_st.busy          = 1'b0;
                    next_st.contract_done = 1'b1;
                    next_st.state         = S_IDLE;
                end else if (ack_done) begin
                    next_st.busy  = 1'b0;
                    next_st.state = S_IDLE;
                end
            end
            default: begin
                // Unreachable codes fall back to idle
                next_st.state = S_IDLE;
            end
        endcase
    end

    // ==========================================
    // State register; synchronous reset leaves outputs low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '{state: S_IDLE, tx_msg: MSG_NONE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // Outputs straight from the state register
    assign link.valid_to_snk = st.tx_valid;
    assign link.msg_to_snk   = st.tx_msg;
    assign supply_change     = st.supply_change;
    assign busy              = st.busy;
    assign contract_done     = st.contract_done;
    assign ready_timeout     = st.ready_timeout;
endmodule

/* File: pkg/vinc_pkg.sv */
package vinc_pkg;

    // ==========================================
    // Message codes on the link
    typedef enum logic [2:0] {
        MSG_NONE    = 3'h0,
        MSG_REQUEST = 3'h1,
        MSG_ACCEPT  = 3'h2,
        MSG_GOODCRC = 3'h3,
        MSG_PS_RDY  = 3'h4
    } msg_e;

    // ==========================================
    // Timer widths and defaults (cycles at 200 MHz)
    localparam int unsigned TIMER_W            = 24;
    localparam logic [23:0] SRC_TRANSITION_RST = 24'h000064;
    localparam logic [23:0] SRC_READY_RST      = 24'h0000c8;
    localparam logic [23:0] SNK_STDBY_RST      = 24'h000032;
    localparam logic [23:0] PS_TRANSITION_RST  = 24'h000400;

endpackage

/* File: pkg/vinc_link_if.sv */
`timescale 1ns/1ps
interface vinc_link_if;
    import vinc_pkg::*;
    // Source to sink message strobe and code
    logic valid_to_snk;
    msg_e msg_to_snk;
    // Sink to source message strobe and code
    logic valid_to_src;
    msg_e msg_to_src;

    modport src (
        output valid_to_snk,
        output msg_to_snk,
        input  valid_to_src,
        input  msg_to_src
    );
    modport snk (
        input  valid_to_snk,
        input  msg_to_snk,
        output valid_to_src,
        output msg_to_src
    );
endinterface

/* File: rtl/wait_timer.sv */
`timescale 1ns/1ps
module wait_timer (
    input  wire logic                             sys_clk,
    input  wire logic                             rst,
    input  wire logic                             start,
    input  wire logic [vinc_pkg::TIMER_W-1:0]     load,
    output logic                                  done
);
    import vinc_pkg::*;

    typedef struct packed {
        logic [TIMER_W-1:0] cnt;
        logic               run;
        logic               done;
    } timer_s;

    timer_s st;
    timer_s next_st;

    // ==========================================
    // Countdown; done pulses when it reaches zero
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (start) begin
            next_st.cnt = (load == '0) ? TIMER_W'(1) : load;
            next_st.run = 1'b1;
        end else if (st.run) begin
            if (st.cnt == TIMER_W'(1)) begin
                next_st.run  = 1'b0;
                next_st.done = 1'b1;
            end
            next_st.cnt = st.cnt - TIMER_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign done = st.done;
endmodule

/* File: rtl/vinc_sink.sv */
`timescale 1ns/1ps
module vinc_sink (
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    vinc_link_if.snk                          link,
    input  wire logic                         request_go,
    input  wire logic [vinc_pkg::TIMER_W-1:0] snk_stdby_cycles,
    input  wire logic [vinc_pkg::TIMER_W-1:0] ps_transition_cycles,
    output logic                              standby_cmd,
    output logic                              new_level_ok,
    output logic                              transition_timeout
);
    import vinc_pkg::*;

    typedef enum logic [1:0] {
        K_IDLE,
        K_WAIT_ACC,
        K_WAIT_RDY
    } snk_state_e;

    typedef struct packed {
        snk_state_e state;
        logic       tx_valid;
        msg_e       tx_msg;
        logic       standby_cmd;
        logic       new_level_ok;
        logic       transition_timeout;
        logic       pst_start;
        logic       stb_start;
        logic       stb_reached;
    } snk_s;

    snk_s st;
    snk_s next_st;
    logic pst_done;
    logic stb_done;
    logic rx_acc;
    logic rx_rdy;

    assign rx_acc = link.valid_to_snk && link.msg_to_snk == MSG_ACCEPT;
    assign rx_rdy = link.valid_to_snk && link.msg_to_snk == MSG_PS_RDY;

    // ==========================================
    // Wait counters
    wait_timer u_pst (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (st.pst_start),
        .load    (ps_transition_cycles),
        .done    (pst_done)
    ); // [R15]

    // Standby deadline; config must keep it below source transition
    wait_timer u_stb (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (st.stb_start),
        .load    (snk_stdby_cycles),
        .done    (stb_done)
    ); // [R15]

    // ==========================================
    // Sequencer
    always_comb begin
        next_st           = st;
        next_st.tx_valid  = 1'b0;
        next_st.tx_msg    = MSG_NONE;
        next_st.pst_start = 1'b0;
        next_st.stb_start = 1'b0;
        if (stb_done) begin
            next_st.stb_reached = 1'b1; // [R6]
        end
        case (st.state)
            K_IDLE: begin
                if (request_go) begin
                    next_st.tx_valid           = 1'b1;
                    next_st.tx_msg             = MSG_REQUEST; // [R1]
                    next_st.new_level_ok       = 1'b0;
                    next_st.stb_reached        = 1'b0;
                    next_st.transition_timeout = 1'b0;
                    next_st.state              = K_WAIT_ACC;
                end
            end
            K_WAIT_ACC: begin
                if (rx_acc) begin
                    next_st.pst_start   = 1'b1; // [R3]
                    next_st.tx_valid    = 1'b1;
                    next_st.tx_msg      = MSG_GOODCRC; // [R4]
                    next_st.stb_start   = 1'b1; // [R6]
                    next_st.standby_cmd = 1'b1; // [R6]
                    next_st.state       = K_WAIT_RDY;
                end
            end
            K_WAIT_RDY: begin
                if (rx_rdy) begin
                    next_st.tx_valid     = 1'b1;
                    next_st.tx_msg       = MSG_GOODCRC; // [R12]
                    // New level only once the standby deadline has passed
                    next_st.new_level_ok = st.stb_reached || stb_done; // [R7] [R12] [R13]
                    // Load ramp, and transients, left to the supply
                    next_st.standby_cmd  = 1'b0; // [R14]
                    next_st.state        = K_IDLE;
                end else if (pst_done) begin
                    next_st.transition_timeout = 1'b1;
                    next_st.standby_cmd        = 1'b0;
                    next_st.state              = K_IDLE;
                end
            end
            default: begin
                next_st.state = K_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '{state: K_IDLE, tx_msg: MSG_NONE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign link.valid_to_src  = st.tx_valid;
    assign link.msg_to_src    = st.tx_msg;
    assign standby_cmd        = st.standby_cmd;
    assign new_level_ok       = st.new_level_ok;
    assign transition_timeout = st.transition_timeout;
endmodule

/* File: dv/vinc_monitor.sv */
`timescale 1ns/1ps
module vinc_monitor
    import vinc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic valid_to_snk,
    input wire msg_e msg_to_snk,
    input wire logic valid_to_src,
    input wire msg_e msg_to_src
);
    // ==========================================
    // Link message steps
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence req_s; valid_to_src && msg_to_src == MSG_REQUEST; endsequence
    sequence acc_s; valid_to_snk && msg_to_snk == MSG_ACCEPT; endsequence
    sequence rdy_s; valid_to_snk && msg_to_snk == MSG_PS_RDY; endsequence
    sequence ack_s; valid_to_src && msg_to_src == MSG_GOODCRC; endsequence

    // ==========================================
    // Ordering, strobe and code checks
    AST_ACCEPT_AFTER_REQUEST: assert property (req_s |=> acc_s)
        else $error("accept did not follow request");
    AST_ACK_AFTER_ACCEPT: assert property (acc_s |=> ack_s)
        else $error("goodcrc did not follow accept");
    AST_ACK_AFTER_PS_RDY: assert property (rdy_s |=> ack_s)
        else $error("goodcrc did not follow ps_rdy");
    // Short fixed gap only; full wait length is checked by the bench
    AST_WAIT_BEFORE_PS_RDY: assert property (acc_s ##1 ack_s |=> (!valid_to_snk) [*8])
        else $error("source spoke during transition wait");
    AST_ACCEPT_CAUSE: assert property (acc_s |-> $past(valid_to_src && msg_to_src == MSG_REQUEST))
        else $error("accept without request");
    AST_ACK_CAUSE: assert property (ack_s |-> $past(valid_to_snk))
        else $error("goodcrc without a source message");
    AST_SRC_PULSE: assert property (valid_to_snk |=> !valid_to_snk)
        else $error("source strobe longer than one cycle");
    AST_SRC_CODES: assert property (valid_to_snk |-> msg_to_snk inside {MSG_ACCEPT, MSG_PS_RDY})
        else $error("illegal source code");
    AST_SNK_CODES: assert property (valid_to_src |-> msg_to_src inside {MSG_REQUEST, MSG_GOODCRC})
        else $error("illegal sink code");
endmodule

/* File: dv/voltage_increase_sequencer_tb.sv */
`timescale 1ns/1ps
`define check_eq(name, exp, got) samples_checked++; if ((got) !== (exp)) begin num_errors++; $display("mismatch %s expected %0h seen %0h", name, exp, got); end
module voltage_increase_sequencer_tb;
    import vinc_pkg::*;
    localparam int SRC_T = 10;
    logic               sys_clk, rst, request_go, supply_ready;
    logic [TIMER_W-1:0] src_transition_cycles, src_ready_cycles, snk_stdby_cycles, ps_transition_cycles;
    logic               supply_change, busy, contract_done, ready_timeout;
    logic               standby_cmd, new_level_ok, transition_timeout;
    logic [10:0]        notes[$];
    logic [10:0]        exp_note;
    logic [7:0]         cnt;
    logic               sc_seen, busy_q, tt_q;
    int                 num_errors, samples_checked;

    vinc_link_if link();
    vinc_source i_vinc_source (.sys_clk(sys_clk), .rst(rst), .link(link),
        .src_transition_cycles(src_transition_cycles), .src_ready_cycles(src_ready_cycles),
        .supply_ready(supply_ready), .supply_change(supply_change), .busy(busy),
        .contract_done(contract_done), .ready_timeout(ready_timeout));
    vinc_sink i_vinc_sink (.sys_clk(sys_clk), .rst(rst), .link(link), .request_go(request_go),
        .snk_stdby_cycles(snk_stdby_cycles), .ps_transition_cycles(ps_transition_cycles),
        .standby_cmd(standby_cmd), .new_level_ok(new_level_ok), .transition_timeout(transition_timeout));
    vinc_monitor i_vinc_monitor (.sys_clk(sys_clk), .rst(rst), .valid_to_snk(link.valid_to_snk),
        .msg_to_snk(link.msg_to_snk), .valid_to_src(link.valid_to_src), .msg_to_src(link.msg_to_src));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ==========================================
    // Result watcher
    always @(negedge sys_clk) begin
        if (contract_done || (transition_timeout && !tt_q)) begin
            exp_note = (notes.size() > 0) ? notes.pop_front() : '1;
            `check_eq("cycles to supply change", exp_note[10:3], cnt)
            `check_eq("new level ok", exp_note[2], new_level_ok)
            `check_eq("ready timeout", exp_note[1], ready_timeout)
            `check_eq("transition timeout", exp_note[0], transition_timeout)
        end
        // Counter keeps its value after busy drops so the done pulse still sees it
        if (busy && !busy_q) begin
            cnt = 8'h01;
            sc_seen = 1'b0;
        end else if (supply_change) begin
            sc_seen = 1'b1;
        end else if (busy && !sc_seen) begin
            cnt = cnt + 8'h01;
        end
        busy_q = busy;
        tt_q = transition_timeout;
    end

    // ==========================================
    // Drivers
    task automatic do_reset();
        rst = 1'b1;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
    endtask

    task automatic contract(input int dly, input logic exp_rt);
        int n;
        notes.push_back({8'(SRC_T + 4), 1'b1, exp_rt, 1'b0});
        request_go = 1'b1;
        @(negedge sys_clk) request_go = 1'b0;
        n = 0;
        while (!supply_change && n < 100) begin @(negedge sys_clk); n++; end
        `check_eq("standby cmd", 1'b1, standby_cmd)
        repeat (dly) @(negedge sys_clk);
        supply_ready = 1'b1;
        n = 0;
        while (!contract_done && n < 100) begin @(negedge sys_clk); n++; end
        `check_eq("done seen", 1'b1, contract_done)
        @(negedge sys_clk) supply_ready = 1'b0;
        `check_eq("standby released", 1'b0, standby_cmd)
        `check_eq("busy released", 1'b0, busy)
        `check_eq("supply change released", 1'b0, supply_change)
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic final_report();
        $display("errors %0d comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        int n;
        void'($urandom(32'heddc57f2));
        {num_errors, samples_checked, cnt, sc_seen, busy_q, tt_q} = '0;
        {rst, request_go, supply_ready} = 3'b100;
        src_transition_cycles = TIMER_W'(SRC_T);
        src_ready_cycles = 24'h000006;
        ps_transition_cycles = 24'h000028;
        snk_stdby_cycles = TIMER_W'(4 + $urandom % (SRC_T - 4));
        do_reset();
        for (int i = 0; i < 4; i++) begin
            contract($urandom % 4, 1'b0);
        end
        // Late supply flags the ready limit but still finishes
        contract(12, 1'b1);
        // Supply never ready: sink gives up, source stays stuck until reset
        notes.push_back({8'(SRC_T + 4), 1'b0, 1'b1, 1'b1});
        request_go = 1'b1;
        @(negedge sys_clk) request_go = 1'b0;
        n = 0;
        while (!transition_timeout && n < 100) begin @(negedge sys_clk); n++; end
        `check_eq("timeout seen", 1'b1, transition_timeout)
        repeat (2) @(negedge sys_clk);
        do_reset();
        contract(1, 1'b0);
        final_report();
    end

    initial begin
        #25000;
        num_errors++;
        $display("mismatch watchdog expected finish seen hang");
        final_report();
    end
endmodule
